// [core/ess_pkg.sv]
package ess_pkg;
  // clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 1000000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // timer settings in seconds
  localparam int unsigned PDOWN_SEC = 10;
  localparam int unsigned CRANK_SEC = 6;
  localparam int unsigned LOCK_SEC = 6;
  localparam int unsigned LAMP_SEC = 2;
  localparam int unsigned RAMP_SEC = 5;
  localparam int unsigned SEC_W = 4;

  // speeds in rpm
  localparam int unsigned RPM_W = 13;
  localparam logic [12:0] CRANK_REL_RPM = 13'h014a;
  localparam logic [12:0] IDLE_RPM = 13'h044c;
  localparam logic [12:0] RATED_RPM = 13'h05dc;
  localparam logic [12:0] IDLE_STEP = 13'h009a;
  localparam logic [12:0] RATED_STEP = 13'h00ce;
  localparam logic [12:0] TRIM_MAX = 13'h0064;
  localparam logic [12:0] TRIM_STEP = 13'h000a;

  // key switch positions
  localparam logic [1:0] KEY_OFF = 2'h0;
  localparam logic [1:0] KEY_RUN = 2'h1;
  localparam logic [1:0] KEY_START = 2'h2;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_LAMP, MODE_SCAN} ess_mode_e;
  typedef enum logic [1:0] {CR_IDLE, CR_ENGAGE, CR_LOCK, CR_HELD} ess_crank_e;
endpackage

// [core/ess_tick.sv]
`timescale 1ns/1ns
module ess_tick #(
  parameter int unsigned CYCLES = ess_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick_q
);
  logic [31:0] cnt_q;

  // free-running divider; one-cycle pulse per second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end
endmodule // ess_tick

// [core/ess_sec_timer.sv]
`timescale 1ns/1ns
module ess_sec_timer #(
  parameter int unsigned W = ess_pkg::SEC_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic arm,
  input wire logic en,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_q;

  // arming restarts from zero and masks a stale done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (arm) begin
      cnt_q <= '0;
    end else if (en && tick && cnt_q < limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = !arm && (cnt_q >= limit);
endmodule // ess_sec_timer

// [core/ess_sequencer.sv]
`timescale 1ns/1ns
module ess_sequencer #(
  parameter int unsigned TICK_CYCLES = ess_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] key_pos,
  input wire logic pdown_disable,
  input wire logic [12:0] engine_rpm,
  input wire logic remote_start,
  input wire logic remote_stop,
  input wire logic tool_start,
  input wire logic tool_stop,
  input wire logic fault_trip,
  input wire logic idle_rated_press,
  input wire logic on_load,
  input wire logic parallel_mode,
  input wire logic speed_raise,
  input wire logic speed_lower,
  input wire logic charge_current_ok,
  input wire logic [6:0] gov_duty_pct,
  output logic power_hold_q,
  output logic lamp_test_q,
  output logic ready_q,
  output logic starter_q,
  output logic fuel_shutoff_valve_q,
  output logic rated_sel_q,
  output logic remote_mode_q,
  output logic [12:0] speed_setpt_q,
  output logic [6:0] act_duty_pct_q,
  output logic charge_fail_led_q
);
  ess_pkg::ess_mode_e mode_q;
  ess_pkg::ess_crank_e crank_q;
  logic tick;
  logic key_on;
  logic key_on_q;
  logic wake;
  logic running;
  logic rem_start_ok;
  logic stop_cmd;
  logic start_held;
  logic start_req;
  logic tool_req_q;
  logic crank_arm_q;
  logic crank_done;
  logic lamp_done;
  logic pd_run;
  logic pd_done;
  logic [3:0] crank_limit;
  logic [12:0] speed_dem_q;
  logic [12:0] trim_q;
  logic [12:0] target;
  logic [12:0] step;

  ess_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick_q(tick)
  );

  assign key_on = (key_pos == ess_pkg::KEY_RUN) || (key_pos == ess_pkg::KEY_START);
  assign wake = key_on && !key_on_q;
  // speed alone decides running and starter release; no oil pressure here
  assign running = engine_rpm >= ess_pkg::CRANK_REL_RPM;
  assign rem_start_ok = remote_start && !remote_stop;
  assign stop_cmd = !key_on || fault_trip || remote_stop || tool_stop;
  // remote input must stay up until the engine fires, else cranking stops
  assign start_held = (key_pos == ess_pkg::KEY_START) || rem_start_ok || tool_req_q;
  assign start_req = start_held && mode_q == ess_pkg::MODE_SCAN && !running && !stop_cmd;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_on_q <= 1'b0;
    end else begin
      key_on_q <= key_on;
    end
  end

  // lamp test timer
  ess_sec_timer u_lamp (
    .clk(clk),
    .rst(rst),
    .arm(wake),
    .en(mode_q == ess_pkg::MODE_LAMP),
    .tick(tick),
    .limit(4'(ess_pkg::LAMP_SEC)),
    .done(lamp_done)
  );

  // power-down timer held at zero unless stopped in run
  assign pd_run = mode_q == ess_pkg::MODE_SCAN && key_pos == ess_pkg::KEY_RUN && !running &&
                  !pdown_disable && crank_q == ess_pkg::CR_IDLE;
  ess_sec_timer u_pdown (
    .clk(clk),
    .rst(rst),
    .arm(!pd_run),
    .en(pd_run),
    .tick(tick),
    .limit(4'(ess_pkg::PDOWN_SEC)),
    .done(pd_done)
  );

  // power state: sleep, lamp test, scan
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= ess_pkg::MODE_SLEEP;
      power_hold_q <= 1'b0;
      lamp_test_q <= 1'b0;
      ready_q <= 1'b0;
    end else if (!key_on) begin
      mode_q <= ess_pkg::MODE_SLEEP;
      power_hold_q <= 1'b0;
      lamp_test_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      case (mode_q)
        ess_pkg::MODE_SLEEP: begin
          // only a fresh key turn wakes after a timed shut-off
          if (wake) begin
            mode_q <= ess_pkg::MODE_LAMP;
            power_hold_q <= 1'b1;
            lamp_test_q <= 1'b1;
          end
        end
        ess_pkg::MODE_LAMP: begin
          if (lamp_done) begin
            mode_q <= ess_pkg::MODE_SCAN;
            lamp_test_q <= 1'b0;
            ready_q <= 1'b1;
          end
        end
        ess_pkg::MODE_SCAN: begin
          if (pd_done) begin
            mode_q <= ess_pkg::MODE_SLEEP;
            power_hold_q <= 1'b0;
            ready_q <= 1'b0;
          end
        end
        default: begin
          mode_q <= ess_pkg::MODE_SLEEP;
        end
      endcase
    end
  end

  // service tool start request latched until it resolves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tool_req_q <= 1'b0;
    end else if (tool_start && !tool_stop) begin
      tool_req_q <= 1'b1;
    end else if (running || stop_cmd || crank_q == ess_pkg::CR_HELD) begin
      tool_req_q <= 1'b0;
    end
  end

  assign crank_limit = (crank_q == ess_pkg::CR_LOCK) ? 4'(ess_pkg::LOCK_SEC) : 4'(ess_pkg::CRANK_SEC);
  ess_sec_timer u_crank (
    .clk(clk),
    .rst(rst),
    .arm(crank_arm_q),
    .en(crank_q == ess_pkg::CR_ENGAGE || crank_q == ess_pkg::CR_LOCK),
    .tick(tick),
    .limit(crank_limit),
    .done(crank_done)
  );

  // starter control; same path for key, remote and tool starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crank_q <= ess_pkg::CR_IDLE;
      starter_q <= 1'b0;
      crank_arm_q <= 1'b0;
    end else begin
      crank_arm_q <= 1'b0;
      case (crank_q)
        ess_pkg::CR_IDLE: begin
          if (start_req) begin
            crank_q <= ess_pkg::CR_ENGAGE;
            starter_q <= 1'b1;
            crank_arm_q <= 1'b1;
          end
        end
        ess_pkg::CR_ENGAGE: begin
          if (!start_held) begin
            crank_q <= ess_pkg::CR_IDLE;
            starter_q <= 1'b0;
          end else if (running || stop_cmd) begin
            crank_q <= ess_pkg::CR_HELD;
            starter_q <= 1'b0;
          end else if (crank_done) begin
            crank_q <= ess_pkg::CR_LOCK;
            starter_q <= 1'b0;
            crank_arm_q <= 1'b1;
          end
        end
        ess_pkg::CR_LOCK: begin
          if (!start_held) begin
            crank_q <= ess_pkg::CR_IDLE;
          end else if (crank_done) begin
            // retry only if still stopped and not told to stop
            if (start_req) begin
              crank_q <= ess_pkg::CR_ENGAGE;
              starter_q <= 1'b1;
              crank_arm_q <= 1'b1;
            end else begin
              crank_q <= ess_pkg::CR_HELD;
            end
          end
        end
        ess_pkg::CR_HELD: begin
          if (!start_held) begin
            crank_q <= ess_pkg::CR_IDLE;
          end
        end
        default: begin
          crank_q <= ess_pkg::CR_IDLE;
          starter_q <= 1'b0;
        end
      endcase
    end
  end

  // fuel valve supply; stop wins for safety
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuel_shutoff_valve_q <= 1'b0;
    end else if (stop_cmd) begin
      fuel_shutoff_valve_q <= 1'b0;
    end else if (wake || (crank_q == ess_pkg::CR_IDLE && start_req)) begin
      fuel_shutoff_valve_q <= 1'b1;
    end
  end

  // idle/rated selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rated_sel_q <= 1'b0;
      remote_mode_q <= 1'b0;
    end else if (crank_q == ess_pkg::CR_IDLE && start_req) begin
      remote_mode_q <= rem_start_ok && key_pos != ess_pkg::KEY_START;
      rated_sel_q <= rem_start_ok && key_pos != ess_pkg::KEY_START;
    end else if (remote_mode_q) begin
      rated_sel_q <= 1'b1;
    end else if (idle_rated_press && !(rated_sel_q && on_load)) begin
      rated_sel_q <= !rated_sel_q;
    end
  end

  // demand ramps from crank speed at a fixed rate per target
  assign target = rated_sel_q ? ess_pkg::RATED_RPM : ess_pkg::IDLE_RPM;
  assign step = rated_sel_q ? ess_pkg::RATED_STEP : ess_pkg::IDLE_STEP;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_dem_q <= 13'h0;
    end else if (!fuel_shutoff_valve_q) begin
      speed_dem_q <= 13'h0;
    end else if (starter_q || speed_dem_q < ess_pkg::CRANK_REL_RPM) begin
      speed_dem_q <= ess_pkg::CRANK_REL_RPM;
    end else if (tick && running) begin
      if (speed_dem_q + step <= target) begin
        speed_dem_q <= speed_dem_q + step;
      end else if (speed_dem_q < target) begin
        speed_dem_q <= target;
      end else if (speed_dem_q > target + step) begin
        speed_dem_q <= speed_dem_q - step;
      end else begin
        speed_dem_q <= target;
      end
    end
  end

  // trim held as offset plus TRIM_MAX so it stays unsigned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_q <= ess_pkg::TRIM_MAX;
    end else if (!running) begin
      trim_q <= ess_pkg::TRIM_MAX;
    end else if (tick && parallel_mode && speed_raise && !speed_lower &&
                 trim_q + ess_pkg::TRIM_STEP <= ess_pkg::TRIM_MAX + ess_pkg::TRIM_MAX) begin
      trim_q <= trim_q + ess_pkg::TRIM_STEP;
    end else if (tick && parallel_mode && speed_lower && !speed_raise && trim_q >= ess_pkg::TRIM_STEP) begin
      trim_q <= trim_q - ess_pkg::TRIM_STEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_setpt_q <= 13'h0;
    end else if (speed_dem_q == 13'h0) begin
      speed_setpt_q <= 13'h0;
    end else begin
      speed_setpt_q <= speed_dem_q + trim_q - ess_pkg::TRIM_MAX;
    end
  end

  // actuator duty doubles as the displayed percentage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_duty_pct_q <= 7'h0;
    end else if (!fuel_shutoff_valve_q || stop_cmd) begin
      act_duty_pct_q <= 7'h0;
    end else if (gov_duty_pct > 7'h64) begin
      act_duty_pct_q <= 7'h64;
    end else begin
      act_duty_pct_q <= gov_duty_pct;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      charge_fail_led_q <= 1'b1;
    end else begin
      charge_fail_led_q <= !charge_current_ok;
    end
  end
endmodule // ess_sequencer

// [test/ess_sequencer_monitor.sv]
`timescale 1ns/1ns
module ess_sequencer_monitor #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] key_pos,
  input wire logic [12:0] engine_rpm,
  input wire logic remote_start,
  input wire logic remote_stop,
  input wire logic fault_trip,
  input wire logic idle_rated_press,
  input wire logic on_load,
  input wire logic charge_current_ok,
  input wire logic power_hold_q,
  input wire logic starter_q,
  input wire logic fuel_shutoff_valve_q,
  input wire logic rated_sel_q,
  input wire logic remote_mode_q,
  input wire logic [6:0] act_duty_pct_q,
  input wire logic charge_fail_led_q
);
  // three cycles of slack for the arm cycle and the output register
  localparam int unsigned CRANK_MAX = ess_pkg::CRANK_SEC * TICK_CYCLES + 3;
  logic [31:0] on_cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      on_cnt_q <= '0;
    else if (starter_q)
      on_cnt_q <= on_cnt_q + 32'h1;
    else
      on_cnt_q <= '0;
  end
  sequence fuel_cut_s;
    !fuel_shutoff_valve_q && act_duty_pct_q == 7'h00;
  endsequence
  key_off_a: assert property (key_pos == ess_pkg::KEY_OFF |=> fuel_cut_s and !power_hold_q)
    else $error("supply kept with key off");
  run_nostart_a: assert property (engine_rpm >= ess_pkg::CRANK_REL_RPM |=> !starter_q)
    else $error("starter driven at running speed");
  stop_fuel_a: assert property (remote_stop |=> fuel_cut_s)
    else $error("fuel kept after remote stop");
  fault_fuel_a: assert property (fault_trip |=> fuel_cut_s)
    else $error("fuel kept after fault trip");
  invalid_start_a: assert property (remote_start && remote_stop |=> !starter_q)
    else $error("start with stop asserted");
  charge_led_a: assert property (1'b1 |=> charge_fail_led_q == !$past(charge_current_ok))
    else $error("charge lamp wrong");
  crank_time_a: assert property (on_cnt_q <= CRANK_MAX)
    else $error("crank longer than limit");
  remote_rated_a: assert property (remote_mode_q && idle_rated_press |=> rated_sel_q)
    else $error("idle taken after remote start");
  load_idle_a: assert property (on_load && rated_sel_q && idle_rated_press |=> rated_sel_q)
    else $error("idle taken on load");
endmodule // ess_sequencer_monitor

// [test/ess_engine_model.sv]
`timescale 1ns/1ns
// engine stand-in: cranks while the relay is in, fires at release speed
module ess_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic starter_q,
  input wire logic fuel_on,
  input wire logic no_fire,
  input wire logic rs_req,
  output logic [12:0] engine_rpm,
  output logic remote_start,
  output logic charge_ok
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      engine_rpm <= '0;
    else if (!fuel_on)
      engine_rpm <= (engine_rpm > 13'h0032) ? engine_rpm - 13'h0032 : 13'h0000;
    else if (engine_rpm >= ess_pkg::CRANK_REL_RPM)
      engine_rpm <= ess_pkg::RATED_RPM;
    else if (starter_q && !no_fire)
      engine_rpm <= engine_rpm + 13'h000a;
    else if (!starter_q)
      engine_rpm <= 13'h0000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remote_start <= 1'b0;
      charge_ok <= 1'b0;
    end else begin
      remote_start <= rs_req && engine_rpm < ess_pkg::CRANK_REL_RPM;
      charge_ok <= engine_rpm >= ess_pkg::CRANK_REL_RPM;
    end
  end
endmodule // ess_engine_model

// [test/test_ess_sequencer.sv]
`timescale 1ns/1ns
module test_ess_sequencer;
  localparam int unsigned T = 20;
  logic clk = 1'b0, rst = 1'b1, pdown_disable = 1'b0, remote_stop = 1'b0, tool_start = 1'b0;
  logic tool_stop = 1'b0, fault_trip = 1'b0, idle_rated_press = 1'b0, on_load = 1'b0;
  logic parallel_mode = 1'b0, speed_raise = 1'b0, speed_lower = 1'b0, no_fire = 1'b0, rs_req = 1'b0;
  logic [1:0] key_pos = 2'h0;
  logic [6:0] gov_duty_pct = 7'h00;
  logic [6:0] act_duty_pct_q;
  logic [12:0] engine_rpm, speed_setpt_q;
  logic remote_start, charge_current_ok, power_hold_q, lamp_test_q, ready_q, starter_q;
  logic fuel_shutoff_valve_q, rated_sel_q, remote_mode_q, charge_fail_led_q;
  int num_errors = 0, check_count = 0;
  always #25 clk = ~clk;
  ess_sequencer #(.TICK_CYCLES(T)) u_ess_sequencer (.clk(clk), .rst(rst), .key_pos(key_pos),
    .pdown_disable(pdown_disable), .engine_rpm(engine_rpm), .remote_start(remote_start),
    .remote_stop(remote_stop), .tool_start(tool_start), .tool_stop(tool_stop), .fault_trip(fault_trip),
    .idle_rated_press(idle_rated_press), .on_load(on_load), .parallel_mode(parallel_mode),
    .speed_raise(speed_raise), .speed_lower(speed_lower), .charge_current_ok(charge_current_ok),
    .gov_duty_pct(gov_duty_pct), .power_hold_q(power_hold_q), .lamp_test_q(lamp_test_q), .ready_q(ready_q),
    .starter_q(starter_q), .fuel_shutoff_valve_q(fuel_shutoff_valve_q), .rated_sel_q(rated_sel_q),
    .remote_mode_q(remote_mode_q), .speed_setpt_q(speed_setpt_q), .act_duty_pct_q(act_duty_pct_q),
    .charge_fail_led_q(charge_fail_led_q));
  ess_engine_model u_ess_engine_model (.clk(clk), .rst(rst), .starter_q(starter_q),
    .fuel_on(fuel_shutoff_valve_q), .no_fire(no_fire), .rs_req(rs_req), .engine_rpm(engine_rpm),
    .remote_start(remote_start), .charge_ok(charge_current_ok));
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // sample on the falling edge, clear of the design's own updates
  task automatic wn(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse_press;
    w(1); idle_rated_press <= 1'b1;
    w(1); idle_rated_press <= 1'b0;
    wn(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    w(5); rst <= 1'b0;
    wn(1); chk(charge_fail_led_q, 1'b1);
    w(1); key_pos <= ess_pkg::KEY_RUN;
    wn(2); chk(lamp_test_q, 1'b1);
    chk(fuel_shutoff_valve_q, 1'b1);
    wn(3 * T); chk(ready_q, 1'b1);
    w(1); pdown_disable <= 1'b1;
    wn(12 * T); chk(power_hold_q, 1'b1);
    w(1); pdown_disable <= 1'b0;
    wn(8 * T); chk(power_hold_q, 1'b1);
    wn(3 * T); chk(power_hold_q, 1'b0);
    w(1); key_pos <= ess_pkg::KEY_OFF;
    w(1); key_pos <= ess_pkg::KEY_RUN;
    wn(3 * T); chk(ready_q, 1'b1);
    w(1); no_fire <= 1'b1; key_pos <= ess_pkg::KEY_START;
    wn(2); chk(starter_q, 1'b1);
    wn(6 * T + T / 2); chk(starter_q, 1'b0);
    wn(2 * T); chk(starter_q, 1'b0);
    w(1); key_pos <= ess_pkg::KEY_RUN;
    w(2); key_pos <= ess_pkg::KEY_START; no_fire <= 1'b0;
    wn(2); chk(starter_q, 1'b1);
    wn(45); chk(starter_q, 1'b0);
    chk(charge_fail_led_q, 1'b0);
    wn(T); chk(starter_q, 1'b0);
    w(1); key_pos <= ess_pkg::KEY_RUN;
    wn(1); chk(rated_sel_q, 1'b0);
    wn(6 * T); chk(speed_setpt_q, ess_pkg::IDLE_RPM);
    pulse_press(); chk(rated_sel_q, 1'b1);
    wn(6 * T); chk(speed_setpt_q, ess_pkg::RATED_RPM);
    w(1); on_load <= 1'b1;
    pulse_press(); chk(rated_sel_q, 1'b1);
    w(1); on_load <= 1'b0; parallel_mode <= 1'b1; speed_raise <= 1'b1;
    wn(12 * T); chk(speed_setpt_q, ess_pkg::RATED_RPM + ess_pkg::TRIM_MAX);
    w(1); speed_raise <= 1'b0; speed_lower <= 1'b1;
    wn(22 * T); chk(speed_setpt_q, ess_pkg::RATED_RPM - ess_pkg::TRIM_MAX);
    w(1); speed_lower <= 1'b0; parallel_mode <= 1'b0; gov_duty_pct <= 7'h7f;
    wn(2); chk(act_duty_pct_q, 7'h64);
    w(1); pdown_disable <= 1'b1; remote_stop <= 1'b1;
    w(1); remote_stop <= 1'b0;
    wn(1); chk(fuel_shutoff_valve_q, 1'b0);
    chk(act_duty_pct_q, 7'h00);
    w(40); rs_req <= 1'b1; remote_stop <= 1'b1;
    wn(2 * T); chk(starter_q, 1'b0);
    w(1); remote_stop <= 1'b0;
    wn(2); chk(starter_q, 1'b1);
    wn(45); chk(fuel_shutoff_valve_q, 1'b1);
    chk(remote_mode_q, 1'b1);
    w(1); rs_req <= 1'b0;
    pulse_press(); chk(rated_sel_q, 1'b1);
    w(1); tool_stop <= 1'b1;
    w(1); tool_stop <= 1'b0;
    wn(1); chk(fuel_shutoff_valve_q, 1'b0);
    w(40); tool_start <= 1'b1;
    w(1); tool_start <= 1'b0;
    wn(4); chk(starter_q, 1'b1);
    w(45); fault_trip <= 1'b1;
    wn(2); chk(fuel_shutoff_valve_q, 1'b0);
    w(1); fault_trip <= 1'b0; key_pos <= ess_pkg::KEY_OFF;
    wn(1); chk(power_hold_q, 1'b0);
    report_and_stop();
  end
  // the sequence needs roughly 2000 cycles
  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule // test_ess_sequencer
bind ess_sequencer ess_sequencer_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.clk(clk), .rst(rst),
  .key_pos(key_pos), .engine_rpm(engine_rpm), .remote_start(remote_start), .remote_stop(remote_stop),
  .fault_trip(fault_trip), .idle_rated_press(idle_rated_press), .on_load(on_load),
  .charge_current_ok(charge_current_ok), .power_hold_q(power_hold_q), .starter_q(starter_q),
  .fuel_shutoff_valve_q(fuel_shutoff_valve_q), .rated_sel_q(rated_sel_q), .remote_mode_q(remote_mode_q),
  .act_duty_pct_q(act_duty_pct_q), .charge_fail_led_q(charge_fail_led_q));
